// ===== hw/tcv_pkg.sv
package tcv_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses on the APB).
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_VALUE_HIGH = 8'h04;
    localparam logic [7:0] OFS_VALUE_LOW = 8'h08;
    localparam logic [7:0] OFS_CHANNEL_STATE = 8'h0C;

    // ----------------------------------------------------------------
    // Field positions inside channel_status_control.
    // ----------------------------------------------------------------
    localparam int unsigned ELS_LSB = 0;
    localparam int unsigned MS_LSB = 2;
    localparam int unsigned CPWM_BIT = 4;
    localparam int unsigned CLKS_LSB = 5;

    // ----------------------------------------------------------------
    // Values after reset.
    // ----------------------------------------------------------------
    localparam logic [1:0] FIELD2_RESET = 2'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [31:0] WORD_RESET = 32'h00000000;

    // ----------------------------------------------------------------
    // Field encodings.
    // ----------------------------------------------------------------
    localparam logic [1:0] ELS_PIN_RELEASED = 2'h0;
    localparam logic [1:0] ELS_HIGH_TRUE = 2'h2;
    localparam logic [1:0] MS_CAPTURE = 2'h0;
    localparam logic [1:0] MS_COMPARE = 2'h1;
    localparam logic [1:0] CLKS_STOPPED = 2'h0;

    // Read-latch state, Gray coded along idle -> latched.
    typedef enum logic [1:0] {
        RL_IDLE = 2'h0,
        RL_HIGH_FIRST = 2'h1,
        RL_LOW_FIRST = 2'h2
    } tcv_latch_t;

endpackage

// ===== hw/tcv_pin_if.sv
// Configuration and match events toward the pin driver, level and enable back.
interface tcv_pin_if;
    logic [1:0] edgeLevel;
    logic [1:0] modeSel;
    logic centreAligned;
    logic match;
    logic countingUp;
    logic reload;
    logic pinLevel;
    logic pinEnable;

    modport ctrl (
        output edgeLevel,
        output modeSel,
        output centreAligned,
        output match,
        output countingUp,
        output reload,
        input pinLevel,
        input pinEnable
    );

    modport pin (
        input edgeLevel,
        input modeSel,
        input centreAligned,
        input match,
        input countingUp,
        input reload,
        output pinLevel,
        output pinEnable
    );
endinterface

// ===== hw/tcv_pin_out.sv
module tcv_pin_out (
    input wire logic clk,
    input wire logic reset_n,
    tcv_pin_if.pin bus
);

    logic levelR;
    logic enableR;

    // ----------------------------------------------------------------
    // Pin enable.
    // ----------------------------------------------------------------

    // The pin is released when edge/level is 00 or in capture mode.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            enableR <= 1'b0;
        end else begin
            enableR <= (bus.edgeLevel != tcv_pkg::ELS_PIN_RELEASED) &&
                       (bus.centreAligned || bus.modeSel != tcv_pkg::MS_CAPTURE);
        end
    end

    // ----------------------------------------------------------------
    // Pin level.
    // ----------------------------------------------------------------

    // Match wins over reload so a zero value gives a zero-width pulse.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            levelR <= 1'b0;
        end else if (bus.centreAligned) begin
            if (bus.match && bus.countingUp) begin
                levelR <= bus.edgeLevel[0];
            end else if (bus.match) begin
                levelR <= ~bus.edgeLevel[0];
            end
        end else if (bus.modeSel[1]) begin
            if (bus.match) begin
                levelR <= bus.edgeLevel[0];
            end else if (bus.reload) begin
                levelR <= ~bus.edgeLevel[0];
            end
        end else if (bus.modeSel == tcv_pkg::MS_COMPARE && bus.match) begin
            unique case (bus.edgeLevel)
                2'h1: levelR <= ~levelR;
                2'h2: levelR <= 1'b0;
                2'h3: levelR <= 1'b1;
                2'h0: levelR <= levelR;
            endcase
        end
    end

    assign bus.pinLevel = levelR;
    assign bus.pinEnable = enableR;

endmodule // tcv_pin_out

// ===== hw/tcv_channel.sv
// How it works
// - Channel value pair is read/write, holds capture or match value, resets to zero.
// - In capture, reading either byte latches both until the other byte is read.
// - Any status/control write releases the read latch, even in debug halt.
// - Value byte writes are ignored while the channel is in capture mode.
// - Debug halt freezes the latch state unless a status/control write clears it.
// - Byte reads during debug halt return the live value, not the buffer.
// - Compare/PWM byte writes buffer; both bytes move together, timed by clock source and mode.
// - Edge/level 00 releases the pin whatever the other mode bits are.
// - Centre-aligned, edge/level 10: clear output on match while counting up.
// - Centre-aligned, edge/level X1: set output on match while counting up.
//
// Design decisions made here: the register offsets and the APB slave port.
module tcv_channel #(
    parameter int unsigned ADDR_WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] counterValue,
    input wire logic counterTick,
    input wire logic counterReload,
    input wire logic countingUp,
    input wire logic captureEvent,
    input wire logic debugHalt,
    output logic pinOut,
    output logic pinOe,
    output logic channelMatch
);

    // ----------------------------------------------------------------
    // Decode helpers.
    // ----------------------------------------------------------------

    function automatic logic addrIs(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] ofs);
        return a == ADDR_WIDTH'(ofs);
    endfunction

    function automatic logic isCapture(input logic cpwm, input logic [1:0] ms);
        return !cpwm && ms == tcv_pkg::MS_CAPTURE;
    endfunction

    logic [1:0] els_r;
    logic [1:0] ms_r;
    logic cpwm_r;
    logic [1:0] clks_r;
    logic [15:0] value_r;
    logic [15:0] rdBuf_r;
    tcv_pkg::tcv_latch_t latch_r;
    logic [7:0] wrHigh_r;
    logic [7:0] wrLow_r;
    logic gotHigh_r;
    logic gotLow_r;
    logic pend_r;
    logic [15:0] pendValue_r;
    logic [31:0] prdata_r;
    logic match_r;

    logic hitCtrl;
    logic hitHigh;
    logic hitLow;
    logic hitState;
    logic setupRead;
    logic accessWrite;
    logic ctrlWrite;
    logic captureMode;
    logic writeHigh;
    logic writeLow;
    logic bothWritten;
    logic transferNow;
    logic liveMatch;
    logic useBuffer;
    logic [15:0] readView;
    logic [7:0] newHigh;
    logic [7:0] newLow;

    tcv_pin_if pinBus ();

    // ----------------------------------------------------------------
    // APB slave.
    // ----------------------------------------------------------------

    // Reads are prepared in the setup cycle, so every access has no wait state.
    assign hitCtrl = addrIs(paddr, tcv_pkg::OFS_STATUS_CONTROL);
    assign hitHigh = addrIs(paddr, tcv_pkg::OFS_VALUE_HIGH);
    assign hitLow = addrIs(paddr, tcv_pkg::OFS_VALUE_LOW);
    assign hitState = addrIs(paddr, tcv_pkg::OFS_CHANNEL_STATE);
    assign setupRead = psel && !penable && !pwrite;
    assign accessWrite = psel && penable && pwrite;
    assign ctrlWrite = accessWrite && hitCtrl;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hitCtrl || hitHigh || hitLow || hitState);
    assign prdata = prdata_r;

    // ----------------------------------------------------------------
    // Channel status and control.
    // ----------------------------------------------------------------

    // Mode fields steer capture, write transfer timing and the pin driver.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            els_r <= tcv_pkg::FIELD2_RESET;
            ms_r <= tcv_pkg::FIELD2_RESET;
            cpwm_r <= 1'b0;
            clks_r <= tcv_pkg::FIELD2_RESET;
        end else if (ctrlWrite) begin
            els_r <= pwdata[tcv_pkg::ELS_LSB +: 2];
            ms_r <= pwdata[tcv_pkg::MS_LSB +: 2];
            cpwm_r <= pwdata[tcv_pkg::CPWM_BIT];
            clks_r <= pwdata[tcv_pkg::CLKS_LSB +: 2];
        end
    end

    assign captureMode = isCapture(cpwm_r, ms_r);

    // ----------------------------------------------------------------
    // Write coherency buffer.
    // ----------------------------------------------------------------

    assign writeHigh = accessWrite && hitHigh && !captureMode;
    assign writeLow = accessWrite && hitLow && !captureMode;
    assign newHigh = writeHigh ? pwdata[7:0] : wrHigh_r;
    assign newLow = writeLow ? pwdata[7:0] : wrLow_r;
    assign bothWritten = (gotHigh_r || writeHigh) && (gotLow_r || writeLow);

    // A stopped counter takes the value at once; compare waits for the next
    // counter step, PWM for the period end so no glitch pulse appears.
    always_comb begin
        if (clks_r == tcv_pkg::CLKS_STOPPED) begin
            transferNow = pend_r;
        end else if (!cpwm_r && ms_r == tcv_pkg::MS_COMPARE) begin
            transferNow = pend_r && counterTick;
        end else begin
            transferNow = pend_r && counterReload;
        end
    end

    // Bytes collect one at a time; a completed pair becomes the pending word.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wrHigh_r <= tcv_pkg::BYTE_RESET;
            wrLow_r <= tcv_pkg::BYTE_RESET;
            gotHigh_r <= 1'b0;
            gotLow_r <= 1'b0;
        end else begin
            wrHigh_r <= newHigh;
            wrLow_r <= newLow;
            if (captureMode || bothWritten) begin
                gotHigh_r <= 1'b0;
                gotLow_r <= 1'b0;
            end else begin
                gotHigh_r <= gotHigh_r || writeHigh;
                gotLow_r <= gotLow_r || writeLow;
            end
        end
    end

    // A new pair arriving as the old one moves wins, so no write is lost.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pend_r <= 1'b0;
            pendValue_r <= tcv_pkg::VALUE_RESET;
        end else if (captureMode) begin
            pend_r <= 1'b0;
        end else if (bothWritten) begin
            pend_r <= 1'b1;
            pendValue_r <= {newHigh, newLow};
        end else if (transferNow) begin
            pend_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Channel value.
    // ----------------------------------------------------------------

    // Capture only while the pin is configured as an input edge source.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            value_r <= tcv_pkg::VALUE_RESET;
        end else if (captureMode) begin
            if (captureEvent && els_r != tcv_pkg::ELS_PIN_RELEASED) begin
                value_r <= counterValue;
            end
        end else if (transferNow) begin
            value_r <= pendValue_r;
        end
    end

    // ----------------------------------------------------------------
    // Read coherency latch.
    // ----------------------------------------------------------------

    // Side effects act at the setup cycle, the same edge the data is taken.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            latch_r <= tcv_pkg::RL_IDLE;
        end else if (ctrlWrite) begin
            latch_r <= tcv_pkg::RL_IDLE;
        end else if (debugHalt) begin
            latch_r <= latch_r;
        end else if (!captureMode) begin
            latch_r <= tcv_pkg::RL_IDLE;
        end else begin
            unique case (latch_r)
                tcv_pkg::RL_IDLE: begin
                    if (setupRead && hitHigh) begin
                        latch_r <= tcv_pkg::RL_HIGH_FIRST;
                    end else if (setupRead && hitLow) begin
                        latch_r <= tcv_pkg::RL_LOW_FIRST;
                    end
                end
                tcv_pkg::RL_HIGH_FIRST: begin
                    if (setupRead && hitLow) begin
                        latch_r <= tcv_pkg::RL_IDLE;
                    end
                end
                tcv_pkg::RL_LOW_FIRST: begin
                    if (setupRead && hitHigh) begin
                        latch_r <= tcv_pkg::RL_IDLE;
                    end
                end
                default: latch_r <= tcv_pkg::RL_IDLE;
            endcase
        end
    end

    // The snapshot is taken on the first byte read of a pair.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdBuf_r <= tcv_pkg::VALUE_RESET;
        end else if (captureMode && !debugHalt && latch_r == tcv_pkg::RL_IDLE &&
                     setupRead && (hitHigh || hitLow)) begin
            rdBuf_r <= value_r;
        end
    end

    // Halted reads see the live value; the latch itself stays untouched.
    assign useBuffer = captureMode && !debugHalt && latch_r != tcv_pkg::RL_IDLE;
    assign readView = useBuffer ? rdBuf_r : value_r;

    // ----------------------------------------------------------------
    // Read data.
    // ----------------------------------------------------------------

    // Narrow registers sit in the low bits; upper bits read as zero.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata_r <= tcv_pkg::WORD_RESET;
        end else if (setupRead) begin
            if (hitCtrl) begin
                prdata_r <= {25'h0000000, clks_r, cpwm_r, ms_r, els_r};
            end else if (hitHigh) begin
                prdata_r <= {24'h000000, readView[15:8]};
            end else if (hitLow) begin
                prdata_r <= {24'h000000, readView[7:0]};
            end else if (hitState) begin
                prdata_r <= {25'h0000000, pinOe, pinOut, pend_r, gotLow_r, gotHigh_r,
                             latch_r};
            end else begin
                prdata_r <= tcv_pkg::WORD_RESET;
            end
        end
    end

    // ----------------------------------------------------------------
    // Match detection and pin driver.
    // ----------------------------------------------------------------

    assign liveMatch = !captureMode && counterTick && counterValue == value_r;

    // Registered copy for the match output keeps channelMatch glitch free.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            match_r <= 1'b0;
        end else begin
            match_r <= liveMatch;
        end
    end

    assign pinBus.edgeLevel = els_r;
    assign pinBus.modeSel = ms_r;
    assign pinBus.centreAligned = cpwm_r;
    assign pinBus.match = liveMatch;
    assign pinBus.countingUp = countingUp;
    assign pinBus.reload = counterReload;

    tcv_pin_out pinDriver (
        .clk(clk),
        .reset_n(reset_n),
        .bus(pinBus.pin)
    );

    assign pinOut = pinBus.pinLevel;
    assign pinOe = pinBus.pinEnable;
    assign channelMatch = match_r;

endmodule // tcv_channel

// ===== sim/tcv_channel_checker.sv
module tcv_channel_checker #(
    parameter int unsigned ADDR_WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] counterValue,
    input wire logic counterTick,
    input wire logic counterReload,
    input wire logic countingUp,
    input wire logic captureEvent,
    input wire logic debugHalt,
    input wire logic pinOut,
    input wire logic pinOe,
    input wire logic channelMatch
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------
    // Helper logic
    // ------------
    logic [7:0] ctrlByte_r;
    logic mapped;
    // The control byte is shadowed from bus writes, so the checker needs no internal probe.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrlByte_r <= 8'h00;
        end else if (psel && penable && pwrite && paddr == 8'h00) begin
            ctrlByte_r <= pwdata[7:0];
        end
    end
    // Only the four decoded word offsets answer without an error.
    assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_centre_on;
        ctrlByte_r[4] && ctrlByte_r[1:0] != 2'h0 && $stable(ctrlByte_r);
    endsequence
    sequence s_up;
        channelMatch && countingUp && $past(countingUp);
    endsequence
    sequence s_down;
        channelMatch && !countingUp && !$past(countingUp);
    endsequence
    a_ready_high: assert property (psel |-> pready) else $error("pready low");
    a_err_decode: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr) else $error("stray pslverr");
    a_reset_clear: assert property ($rose(reset_n) |-> !pinOe && !channelMatch && prdata == 32'h0)
        else $error("outputs not cleared by reset");
    a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata changed without a read");
    a_match_tick: assert property (channelMatch |-> $past(counterTick)) else $error("match without tick");
    a_pin_released: assert property (ctrlByte_r[1:0] == 2'h0 && $past(ctrlByte_r[1:0]) == 2'h0
        |-> !pinOe) else $error("pin driven with edge level 00");
    a_capture_nopin: assert property (ctrlByte_r[4:2] == 3'h0 && $past(ctrlByte_r[4:2]) == 3'h0
        |-> !pinOe) else $error("pin driven in capture");
    a_centre_high: assert property (s_centre_on ##0 s_up ##0 ctrlByte_r[1:0] == 2'h2
        |-> ##[0:2] !pinOut) else $error("high-true pulse not cleared");
    a_centre_low: assert property (s_centre_on ##0 s_up ##0 ctrlByte_r[0]
        |-> ##[0:2] pinOut) else $error("low-true pulse not set");
    a_centre_down: assert property (s_centre_on ##0 s_down
        |-> ##[0:2] pinOut == !ctrlByte_r[0]) else $error("down match wrong level");
endmodule // tcv_channel_checker

// ===== sim/tb_timer_channel_value_coherency.sv
module tb_timer_channel_value_coherency;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] SC = tcv_pkg::OFS_STATUS_CONTROL;
    localparam logic [7:0] HI = tcv_pkg::OFS_VALUE_HIGH;
    localparam logic [7:0] LO = tcv_pkg::OFS_VALUE_LOW;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] counterValue = 16'h0;
    logic counterTick = 1'b0;
    logic counterReload = 1'b0;
    logic countingUp = 1'b0;
    logic captureEvent = 1'b0;
    logic debugHalt = 1'b0;
    logic pinOut;
    logic pinOe;
    logic channelMatch;
    logic lastMatch = 1'b0;
    int errTotal = 0;
    int checksDone = 0;
    int cycles = 0;
    // Free-running 100 MHz clock.
    always #5 clk = ~clk;
    tcv_channel #(.ADDR_WIDTH(8)) i_dut (
        .clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .counterValue, .counterTick, .counterReload, .countingUp,
        .captureEvent, .debugHalt, .pinOut, .pinOe, .channelMatch
    );
    // ----------------------
    // Bus and stimulus tasks
    // ----------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // The request is held until pready is seen high; the wait is bounded by the run timeout.
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(r[7:0], exp);
        chk({7'h0, e}, 8'h00);
    endtask
    // Pulses are one cycle wide, as the counter logic would make them.
    task automatic cap(input logic [15:0] v);
        @(posedge clk);
        counterValue <= v;
        captureEvent <= 1'b1;
        @(posedge clk);
        captureEvent <= 1'b0;
    endtask
    task automatic tick(input logic [15:0] v, input logic up);
        @(posedge clk);
        counterValue <= v;
        countingUp <= up;
        counterTick <= 1'b1;
        @(posedge clk);
        counterTick <= 1'b0;
        // The match pulse stands for the one cycle after the tick.
        @(posedge clk);
        lastMatch = channelMatch;
        repeat (3) @(posedge clk);
    endtask
    // ---------
    // Scenarios
    // ---------
    task automatic testCapture();
        rd(HI, 8'h00);
        rd(LO, 8'h00);
        wr(SC, 8'h01);
        cap(16'hA55A);
        rd(HI, 8'hA5);
        cap(16'h1234);
        rd(LO, 8'h5A);
        rd(HI, 8'h12);
        wr(SC, 8'h01);
        cap(16'h5678);
        rd(LO, 8'h78);
        rd(HI, 8'h56);
        wr(HI, 8'hFF);
        wr(LO, 8'hEE);
        rd(HI, 8'h56);
        rd(LO, 8'h78);
    endtask
    // A read split by a halt must finish with the bytes latched before it.
    task automatic testHalt();
        rd(HI, 8'h56);
        debugHalt <= 1'b1;
        cap(16'h9ABC);
        rd(LO, 8'hBC);
        rd(HI, 8'h9A);
        debugHalt <= 1'b0;
        rd(LO, 8'h78);
        rd(HI, 8'h9A);
        debugHalt <= 1'b1;
        wr(SC, 8'h01);
        cap(16'hDEF0);
        debugHalt <= 1'b0;
        rd(LO, 8'hF0);
    endtask
    task automatic testCompare();
        wr(SC, 8'h05);
        wr(HI, 8'h11);
        wr(LO, 8'h22);
        rd(HI, 8'h11);
        rd(LO, 8'h22);
        wr(SC, 8'h25);
        wr(HI, 8'hAB);
        wr(LO, 8'hCD);
        rd(HI, 8'h11);
        tick(16'h0000, 1'b1);
        rd(HI, 8'hAB);
        rd(LO, 8'hCD);
        wr(HI, 8'h77);
        tick(16'h0000, 1'b1);
        rd(HI, 8'hAB);
    endtask
    task automatic testCentre();
        wr(SC, 8'h32);
        tick(16'hABCD, 1'b0);
        chk({7'h0, pinOut}, 8'h01);
        chk({7'h0, pinOe}, 8'h01);
        chk({7'h0, lastMatch}, 8'h01);
        tick(16'hABCD, 1'b1);
        chk({7'h0, pinOut}, 8'h00);
        wr(SC, 8'h31);
        tick(16'hABCD, 1'b1);
        chk({7'h0, pinOut}, 8'h01);
        tick(16'hABCD, 1'b0);
        chk({7'h0, pinOut}, 8'h00);
        wr(SC, 8'h30);
        repeat (3) @(posedge clk);
        chk({7'h0, pinOe}, 8'h00);
    endtask
    task automatic testUnmapped();
        logic [31:0] r;
        logic e;
        apb(1'b0, 8'h10, 8'h00, r, e);
        chk({7'h0, e}, 8'h01);
        chk(r[7:0], 8'h00);
    endtask
    // Edge PWM moves a completed pair only at the period end, never on a plain tick.
    task automatic testPwm();
        wr(SC, 8'h2A);
        wr(HI, 8'h12);
        wr(LO, 8'h34);
        tick(16'h1234, 1'b1);
        chk({7'h0, lastMatch}, 8'h00);
        rd(HI, 8'hAB);
        @(posedge clk);
        counterReload <= 1'b1;
        @(posedge clk);
        counterReload <= 1'b0;
        rd(HI, 8'h12);
        rd(LO, 8'h34);
    endtask
    // A reset in mid-run must clear a non-zero value pair and release the pin.
    task automatic testReset();
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(HI, 8'h00);
        rd(LO, 8'h00);
        chk({7'h0, pinOe}, 8'h00);
    endtask
    // -----------
    // Run control
    // -----------
    task automatic finalReport();
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // A hung handshake ends here rather than stalling the run.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errTotal++;
            $display("MISMATCH t=%0t timeout", $time);
            finalReport();
        end
    end
    // Main sequence after the reset hold.
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        testCapture();
        testHalt();
        testCompare();
        testCentre();
        testPwm();
        testUnmapped();
        testReset();
        finalReport();
    end
endmodule // tb_timer_channel_value_coherency

bind tcv_channel tcv_channel_checker #(.ADDR_WIDTH(ADDR_WIDTH)) i_chk (
    .clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .counterValue, .counterTick, .counterReload, .countingUp,
    .captureEvent, .debugHalt, .pinOut, .pinOe, .channelMatch
);
